// [design/tx_descriptor_queue_walker.sv]
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`include "tx_walker_defs.svh"

module tx_descriptor_queue_walker (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// ahb-lite register slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// shared memory word port
	output logic             memReq,
	output logic             memWrite,
	output logic [31:0]      memAddr,
	output logic [31:0]      memWdata,
	input  wire logic        memAck,
	input  wire logic [31:0] memRdata,
	// transmit byte stream
	output logic             txValid,
	output logic [7:0]       txData,
	output logic             txLast,
	input  wire logic        txReady
);

	tx_walker_pkg::walk_state_t stateQ, stateD, postState;

	logic [31:0] curQ, linkQ, bufQ, flagsQ, sopDescQ, sopFlagsQ;
	logic [15:0] offQ, fragLenQ, pktLenQ, cntQ;
	logic [31:0] cacheQ, crcQ, cpQ, ackQ, hrdataQ;
	logic [29:0] cacheAddrQ;
	logic [1:0]  crcIdxQ;
	logic [3:0]  regAddrQ;
	logic        cacheValidQ, wrPendQ, tdReqQ, tdDoneQ, eoqHaltQ;

	// one crc-32 step over a byte, lsb first as the wire sends it
	function automatic logic [31:0] crcStep(input logic [31:0] crc, input logic [7:0] b);
		logic [31:0] c;
		c = crc ^ {24'h00_0000, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ `TXW_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crcStep

	// little-endian byte lane of a word
	function automatic logic [7:0] laneByte(input logic [31:0] w, input logic [1:0] idx);
		return w[{idx, 3'b000} +: 8];
	endfunction : laneByte

	// bus decode; zero wait states, so hreadyout never stalls the master
	wire busAct   = hsel & htrans[1] & hready;
	wire busy     = (stateQ != tx_walker_pkg::S_IDLE);
	wire headWr   = wrPendQ && (regAddrQ == `TXW_REG_HEAD) && !busy;
	wire complWr  = wrPendQ && (regAddrQ == `TXW_REG_COMPL);
	wire ctrlWr   = wrPendQ && (regAddrQ == `TXW_REG_CTRL);
	wire ackPend  = (cpQ != ackQ);
	wire [31:0] statWord = {pktLenQ, 12'h000, ackPend, tdDoneQ, eoqHaltQ, busy};
	wire [31:0] readMux  = (haddr[3:0] == `TXW_REG_HEAD)  ? curQ :
	                       (haddr[3:0] == `TXW_REG_COMPL) ? cpQ :
	                       (haddr[3:0] == `TXW_REG_CTRL)  ? {31'h0, tdReqQ} :
	                       (haddr[3:0] == `TXW_REG_STAT)  ? statWord : 32'h0000_0000;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdataQ;

	// descriptor field views
	wire isSop   = flagsQ[`TXW_BIT_SOP];
	wire isEop   = flagsQ[`TXW_BIT_EOP];
	wire swCrc   = isSop ? flagsQ[`TXW_BIT_SWCRC] : sopFlagsQ[`TXW_BIT_SWCRC];
	wire sameDsc = (curQ == sopDescQ);
	// offset only honoured on the packet-start descriptor
	wire [31:0] skip     = isSop ? {16'h0000, offQ} : 32'h0000_0000;
	wire [31:0] byteAddr = bufQ + skip + {16'h0000, cntQ};
	wire        cacheHit = cacheValidQ && (cacheAddrQ == byteAddr[31:2]);
	wire        lastData = ((cntQ + 16'h0001) == fragLenQ);
	wire        emitTake = (stateQ == tx_walker_pkg::S_EMIT) && txReady;
	wire        crcTake  = (stateQ == tx_walker_pkg::S_CRC) && txReady;

	// stream outputs; the crc goes out inverted, low byte first
	assign txValid = (stateQ == tx_walker_pkg::S_EMIT) || (stateQ == tx_walker_pkg::S_CRC);
	assign txData  = (stateQ == tx_walker_pkg::S_CRC) ? laneByte(~crcQ, crcIdxQ)
	                                                   : laneByte(cacheQ, byteAddr[1:0]);
	assign txLast  = ((stateQ == tx_walker_pkg::S_EMIT) && lastData && isEop && swCrc) ||
	                 ((stateQ == tx_walker_pkg::S_CRC) && (crcIdxQ == `TXW_CRC_LAST));

	// memory port: only word three is ever written back
	always_comb begin
		memReq   = 1'b0;
		memWrite = 1'b0;
		memAddr  = curQ;
		memWdata = 32'h0000_0000;
		case (stateQ)
			tx_walker_pkg::S_LINK, tx_walker_pkg::S_RELINK: begin
				memReq  = 1'b1;
				memAddr = curQ + `TXW_WORD_NEXT;
			end
			tx_walker_pkg::S_BUF: begin
				memReq  = 1'b1;
				memAddr = curQ + `TXW_WORD_BUF;
			end
			tx_walker_pkg::S_OFF: begin
				memReq  = 1'b1;
				memAddr = curQ + `TXW_WORD_OFFLEN;
			end
			tx_walker_pkg::S_FLG: begin
				memReq  = 1'b1;
				memAddr = curQ + `TXW_WORD_FLGLEN;
			end
			tx_walker_pkg::S_FETCHB: begin
				memReq  = !cacheHit;
				memAddr = {byteAddr[31:2], 2'b00};
			end
			tx_walker_pkg::S_EOQ: begin
				memReq   = 1'b1;
				memWrite = 1'b1;
				memAddr  = curQ + `TXW_WORD_FLGLEN;
				memWdata = flagsQ | (32'h1 << `TXW_BIT_EOQ);
				if (sameDsc) begin
					memWdata[`TXW_BIT_OWN] = 1'b0;
				end
			end
			tx_walker_pkg::S_OWN: begin
				memReq   = 1'b1;
				memWrite = 1'b1;
				memAddr  = sopDescQ + `TXW_WORD_FLGLEN;
				memWdata = sopFlagsQ & ~(32'h1 << `TXW_BIT_OWN);
			end
			tx_walker_pkg::S_TDOWN: begin
				memReq   = 1'b1;
				memWrite = 1'b1;
				memAddr  = curQ + `TXW_WORD_FLGLEN;
				memWdata = (flagsQ | (32'h1 << `TXW_BIT_TDOWN)) & ~(32'h1 << `TXW_BIT_OWN);
			end
			default: begin
				memReq = 1'b0;
			end
		endcase
	end

	// where a finished fragment leads
	always_comb begin
		if (isEop) begin
			postState = swCrc ? tx_walker_pkg::S_RELINK : tx_walker_pkg::S_CRC;
		end else if (linkQ != 32'h0000_0000) begin
			postState = tx_walker_pkg::S_LINK;
		end else begin
			postState = tx_walker_pkg::S_RELINK;
		end
	end

	// walker sequencing
	always_comb begin
		stateD = stateQ;
		case (stateQ)
			tx_walker_pkg::S_IDLE:   if (headWr) stateD = tx_walker_pkg::S_LINK;
			tx_walker_pkg::S_LINK:   if (memAck) stateD = tx_walker_pkg::S_BUF;
			tx_walker_pkg::S_BUF:    if (memAck) stateD = tx_walker_pkg::S_OFF;
			tx_walker_pkg::S_OFF:    if (memAck) stateD = tx_walker_pkg::S_FLG;
			tx_walker_pkg::S_FLG:    if (memAck) stateD = tx_walker_pkg::S_DECIDE;
			tx_walker_pkg::S_DECIDE: begin
				if (isSop && tdReqQ) begin
					stateD = tx_walker_pkg::S_TDOWN;
				end else if (fragLenQ == 16'h0000) begin
					stateD = postState;
				end else begin
					stateD = tx_walker_pkg::S_FETCHB;
				end
			end
			tx_walker_pkg::S_FETCHB: if (cacheHit || memAck) stateD = tx_walker_pkg::S_EMIT;
			tx_walker_pkg::S_EMIT: begin
				if (txReady) begin
					stateD = lastData ? postState : tx_walker_pkg::S_FETCHB;
				end
			end
			tx_walker_pkg::S_CRC: begin
				if (crcTake && (crcIdxQ == `TXW_CRC_LAST)) stateD = tx_walker_pkg::S_RELINK;
			end
			tx_walker_pkg::S_RELINK: begin
				// the link is read again here so a late patch is still seen
				if (memAck) begin
					if (memRdata == 32'h0000_0000) begin
						stateD = isEop ? tx_walker_pkg::S_EOQ : tx_walker_pkg::S_IDLE;
					end else begin
						stateD = isEop ? tx_walker_pkg::S_OWN : tx_walker_pkg::S_LINK;
					end
				end
			end
			tx_walker_pkg::S_EOQ: begin
				if (memAck) stateD = sameDsc ? tx_walker_pkg::S_IDLE : tx_walker_pkg::S_OWN;
			end
			tx_walker_pkg::S_OWN: begin
				if (memAck) begin
					stateD = (linkQ == 32'h0000_0000) ? tx_walker_pkg::S_IDLE : tx_walker_pkg::S_LINK;
				end
			end
			tx_walker_pkg::S_TDOWN:  if (memAck) stateD = tx_walker_pkg::S_IDLE;
			default:                 stateD = tx_walker_pkg::S_IDLE;
		endcase
	end

	wire pktDone  = memAck && (((stateQ == tx_walker_pkg::S_EOQ) && sameDsc) ||
	                           (stateQ == tx_walker_pkg::S_OWN));
	wire tdFinish = (memAck && (stateQ == tx_walker_pkg::S_TDOWN)) ||
	                (!busy && tdReqQ);

	// bus slave registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wrPendQ  <= 1'b0;
			regAddrQ <= 4'h0;
			hrdataQ  <= 32'h0000_0000;
		end else begin
			wrPendQ  <= busAct && hwrite;
			regAddrQ <= busAct ? haddr[3:0] : regAddrQ;
			hrdataQ  <= (busAct && !hwrite) ? readMux : hrdataQ;
		end
	end

	// software-visible state; a teardown request wins over its own clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ackQ     <= 32'h0000_0000;
			cpQ      <= 32'h0000_0000;
			tdReqQ   <= 1'b0;
			tdDoneQ  <= 1'b0;
			eoqHaltQ <= 1'b0;
		end else begin
			if (complWr) ackQ <= hwdata;
			if (pktDone || (memAck && (stateQ == tx_walker_pkg::S_TDOWN))) cpQ <= curQ;
			if (ctrlWr && hwdata[`TXW_CTRL_TDOWN]) tdReqQ <= 1'b1;
			else if (tdFinish) tdReqQ <= 1'b0;
			if (tdFinish) tdDoneQ <= 1'b1;
			else if (headWr) tdDoneQ <= 1'b0;
			if (memAck && (stateQ == tx_walker_pkg::S_EOQ)) eoqHaltQ <= 1'b1;
			else if (headWr) eoqHaltQ <= 1'b0;
		end
	end

	// descriptor fields, latched as each word arrives
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stateQ   <= tx_walker_pkg::S_IDLE;
			curQ     <= 32'h0000_0000;
			linkQ    <= 32'h0000_0000;
			bufQ     <= 32'h0000_0000;
			offQ     <= 16'h0000;
			fragLenQ <= 16'h0000;
			flagsQ   <= 32'h0000_0000;
		end else begin
			stateQ <= stateD;
			// step only on entry, so a slow link fetch keeps its address; a late
			// patch is taken straight off the bus since linkQ only loads at this edge
			if (headWr) curQ <= hwdata;
			else if ((stateD == tx_walker_pkg::S_LINK) && (stateQ != tx_walker_pkg::S_LINK))
				curQ <= (stateQ == tx_walker_pkg::S_RELINK) ? memRdata : linkQ;
			if (memAck && ((stateQ == tx_walker_pkg::S_LINK) || (stateQ == tx_walker_pkg::S_RELINK)))
				linkQ <= memRdata;
			if (memAck && (stateQ == tx_walker_pkg::S_BUF)) bufQ <= memRdata;
			if (memAck && (stateQ == tx_walker_pkg::S_OFF)) begin
				offQ     <= memRdata[31:16];
				fragLenQ <= memRdata[15:0];
			end
			if (memAck && (stateQ == tx_walker_pkg::S_FLG)) flagsQ <= memRdata;
		end
	end

	// per-packet state, taken from the packet-start descriptor only
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sopDescQ  <= 32'h0000_0000;
			sopFlagsQ <= 32'h0000_0000;
			pktLenQ   <= 16'h0000;
		end else if ((stateQ == tx_walker_pkg::S_DECIDE) && isSop) begin
			sopDescQ  <= curQ;
			sopFlagsQ <= flagsQ;
			pktLenQ   <= flagsQ[15:0];
		end
	end

	// byte walk, word cache and crc; the cache saves three of four reads
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cntQ        <= 16'h0000;
			cacheQ      <= 32'h0000_0000;
			cacheAddrQ  <= 30'h0;
			cacheValidQ <= 1'b0;
			crcQ        <= `TXW_CRC_INIT;
			crcIdxQ     <= 2'h0;
		end else begin
			if (stateQ == tx_walker_pkg::S_DECIDE) begin
				cntQ        <= 16'h0000;
				cacheValidQ <= 1'b0;
				crcIdxQ     <= 2'h0;
				if (isSop) crcQ <= `TXW_CRC_INIT;
			end
			if (emitTake) begin
				cntQ <= cntQ + 16'h0001;
				crcQ <= crcStep(crcQ, txData);
			end
			if (memAck && (stateQ == tx_walker_pkg::S_FETCHB)) begin
				cacheQ      <= memRdata;
				cacheAddrQ  <= byteAddr[31:2];
				cacheValidQ <= 1'b1;
			end
			if (crcTake) crcIdxQ <= crcIdxQ + 2'h1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence fetchWords_s;
		(stateQ == tx_walker_pkg::S_LINK) && memAck ##1 (stateQ == tx_walker_pkg::S_BUF);
	endsequence

	fetch_order_a: assert property (
		fetchWords_s |-> memAddr == curQ + `TXW_WORD_BUF)
		else $error("buffer word not fetched right after link word");

	write_word3_a: assert property (
		memReq && memWrite |-> (memAddr == curQ + `TXW_WORD_FLGLEN) ||
		                       (memAddr == sopDescQ + `TXW_WORD_FLGLEN))
		else $error("write outside the flags word");

	held_by_controller_flag_clear_a: assert property (
		(stateQ == tx_walker_pkg::S_OWN) && memReq |-> !memWdata[`TXW_BIT_OWN] &&
		(($past(stateQ) == tx_walker_pkg::S_RELINK) ||
		 ($past(stateQ) == tx_walker_pkg::S_EOQ) ||
		 ($past(stateQ) == tx_walker_pkg::S_OWN)))
		else $error("ownership write not after packet end");

	eoq_null_a: assert property (
		(stateQ == tx_walker_pkg::S_RELINK) && memAck && isEop && (memRdata == 32'h0)
		|=> (stateQ == tx_walker_pkg::S_EOQ) && memWdata[`TXW_BIT_EOQ])
		else $error("null link on packet end did not mark queue end");

	crc_four_a: assert property (
		$rose(stateQ == tx_walker_pkg::S_CRC) |-> !swCrc && (crcIdxQ == 2'h0))
		else $error("crc appended while software supplies it");

	first_byte_a: assert property (
		(stateQ == tx_walker_pkg::S_FETCHB) && (cntQ == 16'h0) && isSop
		|-> byteAddr == bufQ + {16'h0000, offQ})
		else $error("first byte address ignores offset");

	stream_only_a: assert property (
		txValid |-> (stateQ == tx_walker_pkg::S_EMIT) || (stateQ == tx_walker_pkg::S_CRC))
		else $error("stream valid outside send states");

	byte_hold_a: assert property (
		txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
		else $error("stream byte changed before it was taken");

	teardown_stop_a: assert property (
		(stateQ == tx_walker_pkg::S_TDOWN) && memAck |=> !busy ##1 !txValid)
		else $error("walker continued after teardown");

	head_ignore_a: assert property (
		wrPendQ && (regAddrQ == `TXW_REG_HEAD) && busy |=> $stable(stateQ) || busy)
		else $error("head write disturbed an active list");

endmodule : tx_descriptor_queue_walker

// [design/tx_walker_defs.svh]
`ifndef TX_WALKER_DEFS_SVH
`define TX_WALKER_DEFS_SVH

// register byte offsets on the AHB-Lite slave
`define TXW_REG_HEAD      4'h0
`define TXW_REG_COMPL     4'h4
`define TXW_REG_CTRL      4'h8
`define TXW_REG_STAT      4'hC

// descriptor word offsets from the descriptor base
`define TXW_WORD_NEXT     32'h0000_0000
`define TXW_WORD_BUF      32'h0000_0004
`define TXW_WORD_OFFLEN   32'h0000_0008
`define TXW_WORD_FLGLEN   32'h0000_000C

// bits of the flags_length_word
`define TXW_BIT_SOP       31
`define TXW_BIT_EOP       30
`define TXW_BIT_OWN       29
`define TXW_BIT_EOQ       28
`define TXW_BIT_TDOWN     27
`define TXW_BIT_SWCRC     26

// control and status bit positions
`define TXW_CTRL_TDOWN    0
`define TXW_ST_BUSY       0
`define TXW_ST_EOQ        1
`define TXW_ST_TDOWN      2
`define TXW_ST_ACKPEND    3

// crc-32, reflected form
`define TXW_CRC_POLY      32'hEDB8_8320
`define TXW_CRC_INIT      32'hFFFF_FFFF
`define TXW_CRC_LAST      2'h3

`endif

// [design/tx_walker_pkg.sv]
package tx_walker_pkg;

	typedef enum logic [3:0] {
		S_IDLE,
		S_LINK,
		S_BUF,
		S_OFF,
		S_FLG,
		S_DECIDE,
		S_FETCHB,
		S_EMIT,
		S_CRC,
		S_RELINK,
		S_EOQ,
		S_OWN,
		S_TDOWN
	} walk_state_t;

endpackage : tx_walker_pkg

// [tb/shared_mem_model.sv]
module shared_mem_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// memory word port
	input  wire logic        memReq,
	input  wire logic        memWrite,
	input  wire logic [31:0] memAddr,
	input  wire logic [31:0] memWdata,
	input  wire logic [1:0]  waitCycles,
	output logic             memAck,
	output logic [31:0]      memRdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:255];
	logic [31:0] rdata_q;
	logic [1:0]  waitCnt_q;
	// descriptors are whole aligned words, filled in by the bench
	initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
	// off the ack cycle the bus shows the inverse, so stale data never looks valid
	assign memRdata = memAck ? rdata_q : ~rdata_q;
	// answer after a varying wait; a slow answer keeps the request held
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			memAck    <= 1'b0;
			waitCnt_q <= 2'h0;
			rdata_q   <= 32'h0;
		end else if (memReq && !memAck && waitCnt_q >= waitCycles) begin
			memAck    <= 1'b1;
			waitCnt_q <= 2'h0;
			rdata_q   <= mem[memAddr[9:2]];
			if (memWrite) begin
				mem[memAddr[9:2]] <= memWdata;
			end
		end else begin
			memAck    <= 1'b0;
			waitCnt_q <= (memReq && !memAck) ? waitCnt_q + 2'h1 : 2'h0;
		end
	end
endmodule : shared_mem_model

// [tb/tb_tx_descriptor_queue_walker.sv]
`define CHK(nm, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) begin \
			n_fail++; \
			$display("BAD %s expected %h seen %h", nm, e, g); \
		end \
	end

module tb_tx_descriptor_queue_walker;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] fStart = 16'h8000, fEnd = 16'h4000, fHeld = 16'h2000;
	localparam logic [15:0] fQend = 16'h1000, fTdone = 16'h0800, fSwcrc = 16'h0400;
	logic        clock;
	logic        arst_n     = 1'b0;
	logic        hsel       = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h0;
	logic        txReady    = 1'b0;
	logic [1:0]  waitCycles = 2'h0;
	logic [31:0] rnd        = 32'hA83BDA52;
	logic [31:0] crc, rd;
	logic        swc;
	logic [31:0] sh [0:255] = '{default: 32'h0};
	logic [7:0]  exp[$], got[$];
	logic        expLast[$], lastSeen[$];
	int          n_fail     = 0;
	int          cmp_count  = 0;
	wire         hreadyout, hresp, memReq, memWrite, memAck, txValid, txLast;
	wire  [31:0] hrdata, memAddr, memWdata, memRdata;
	wire  [7:0]  txData;

	tx_descriptor_queue_walker tx_descriptor_queue_walker_inst (
		.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .memReq(memReq),
		.memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
		.memRdata(memRdata), .txValid(txValid), .txData(txData), .txLast(txLast),
		.txReady(txReady));
	shared_mem_model shared_mem_model_inst (
		.clock(clock), .arst_n(arst_n), .memReq(memReq), .memWrite(memWrite),
		.memAddr(memAddr), .memWdata(memWdata), .waitCycles(waitCycles),
		.memAck(memAck), .memRdata(memRdata));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr
	// reflected crc-32, one byte at a time
	function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
		c = c ^ {24'h0, b};
		for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		return c;
	endfunction : crc8

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// byte sink with random stalls; memory wait varies too
	always @(posedge clock) begin
		if (txValid === 1'b1 && txReady) begin
			got.push_back(txData);
			lastSeen.push_back(txLast);
		end
		rnd        <= lfsr(rnd);
		txReady    <= rnd[0] | rnd[1];
		waitCycles <= rnd[5:4];
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run
	// every wait is bounded; running out ends the run as a mismatch
	task automatic hang(input int n);
		if (n > 400) begin
			n_fail++;
			complete_run();
		end
	endtask : hang
	// one single transfer: address phase, then data phase, each held until hready
	task automatic ahb(input logic wr, input logic [31:0] a, wd);
		int n;
		n = 0;
		@(posedge clock);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		@(posedge clock);
		while (hreadyout !== 1'b1) begin @(posedge clock); hang(++n); end
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clock);
		while (hreadyout !== 1'b1) begin @(posedge clock); hang(++n); end
		rd = hrdata;
	endtask : ahb
	task automatic wr_word(input logic [31:0] a, w);
		sh[a[9:2]] = w;
		shared_mem_model_inst.mem[a[9:2]] = w;
	endtask : wr_word
	task automatic wr_byte(input logic [31:0] a, input logic [7:0] b);
		logic [31:0] w;
		w = sh[a[9:2]];
		w[a[1:0] * 8 +: 8] = b;
		wr_word(a, w);
	endtask : wr_byte
	// descriptor and its buffer, plus the bytes the stream should carry
	task automatic mk(input logic [31:0] d, nx, bf, input logic [15:0] off, len, fl, pl);
		logic [7:0] b;
		wr_word(d, nx);
		wr_word(d + 4, bf);
		wr_word(d + 8, {off, len});
		wr_word(d + 12, {fl, pl});
		if (fl[15]) begin
			crc = 32'hFFFFFFFF;
			swc = fl[10];
		end
		for (int i = 0; i < len; i++) begin
			b = 8'(rnd[7:0] + i * 37 + d[7:0]);
			wr_byte(bf + (fl[15] ? {16'h0, off} : 32'h0) + i, b);
			exp.push_back(b);
			expLast.push_back(fl[14] && swc && i == len - 1);
			crc = crc8(crc, b);
		end
		for (int i = 0; fl[14] && !swc && i < 4; i++) begin
			exp.push_back(~crc[8 * i +: 8]);
			expLast.push_back(i == 3);
		end
	endtask : mk
	task automatic mark(input logic [31:0] d, input logic [15:0] set, clr);
		sh[d[9:2] + 3] = (sh[d[9:2] + 3] | {set, 16'h0}) & ~{clr, 16'h0};
	endtask : mark
	// wait for idle, then compare the stream and every memory word
	task automatic settle();
		int n;
		n = 0;
		rd = 32'h1;
		while (rd[0] !== 1'b0) begin ahb(1'b0, 32'hC, 32'h0); hang(++n); end
		`CHK("frame size", exp.size(), got.size())
		foreach (exp[i]) begin
			if (i < got.size()) begin
				`CHK("tx byte", exp[i], got[i])
				`CHK("tx last", expLast[i], lastSeen[i])
			end
		end
		for (int i = 0; i < 256; i++) `CHK("mem word", sh[i], shared_mem_model_inst.mem[i])
		exp.delete();
		expLast.delete();
		got.delete();
		lastSeen.delete();
	endtask : settle

	initial begin
		repeat (60000) @(posedge clock);
		n_fail++;
		complete_run();
	end

	initial begin
		int n;
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		// one-fragment packet with offset, then two fragments carrying their own crc
		mk(32'h100, 32'h110, 32'h200, 16'h3, 16'h5, fStart | fEnd | fHeld, 16'h5);
		mk(32'h110, 32'h120, 32'h211, 16'h2, 16'h6, fStart | fHeld | fSwcrc, 16'h9);
		mk(32'h120, 32'h0, 32'h241, 16'h7, 16'h3, fEnd, 16'h0);
		mark(32'h100, 16'h0, fHeld);
		mark(32'h110, 16'h0, fHeld);
		mark(32'h120, fQend, 16'h0);
		ahb(1'b1, 32'h0, 32'h100);
		settle();
		ahb(1'b0, 32'h4, 32'h0);
		`CHK("completion", 32'h120, rd)
		ahb(1'b0, 32'hC, 32'h0);
		`CHK("status", 4'hA, rd[3:0])
		ahb(1'b1, 32'h4, 32'h120);
		ahb(1'b0, 32'hC, 32'h0);
		`CHK("ack pending", 1'b0, rd[3])
		// restart after the halt with a one-byte packet
		mk(32'h130, 32'h0, 32'h2F0, 16'h0, 16'h1, fStart | fEnd | fHeld, 16'h1);
		mark(32'h130, fQend, fHeld);
		ahb(1'b1, 32'h0, 32'h130);
		settle();
		ahb(1'b0, 32'h4, 32'h0);
		`CHK("completion", 32'h130, rd)
		// teardown while the first of three packets is on the wire
		mk(32'h140, 32'h150, 32'h260, 16'h0, 16'hC, fStart | fEnd | fHeld, 16'hC);
		n = exp.size();
		mk(32'h150, 32'h160, 32'h280, 16'h0, 16'h4, fStart | fEnd | fHeld, 16'h4);
		mk(32'h160, 32'h0, 32'h290, 16'h0, 16'h4, fStart | fEnd | fHeld, 16'h4);
		while (exp.size() > n) begin
			exp.pop_back();
			expLast.pop_back();
		end
		mark(32'h140, 16'h0, fHeld);
		mark(32'h150, fTdone, fHeld);
		ahb(1'b1, 32'h0, 32'h140);
		n = 0;
		while (got.size() == 0) begin @(posedge clock); hang(++n); end
		ahb(1'b1, 32'h8, 32'h1);
		settle();
		ahb(1'b0, 32'hC, 32'h0);
		`CHK("teardown done", 1'b1, rd[2])
		ahb(1'b0, 32'h4, 32'h0);
		`CHK("completion", 32'h150, rd)
		complete_run();
	end
endmodule : tb_tx_descriptor_queue_walker
